// >>> timer_interrupt_flags.sv
// Interrupt enable and request flags for timers A and C and their sibling sources
//
// Behaviour
// RQ1: Enable register one bit 5 allows the timer A overflow request.
// RQ2: Request register one flags timer A, external 4, 3, 1, 0, event counter.
// RQ3: Timer A flag, bit 7, sets on count FF to 00; writing 0 clears.
// RQ4: Enable register two bit 1 allows timer C overflow and underflow requests.
// RQ5: Request register two flags transition, converter, timers G, FH, FL, C, counter.
// RQ6: Timer C flag, bit 7, sets on FF to 00 or 00 to FF; zero clears.
// RQ7: A request goes out only while flag and enable are both one; writing one keeps. IRQ_O is raised from status and mask alone.
//
// The APB interface to the registers was decided locally.
module timer_interrupt_flags
  import irq_flags_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Event sources
  input wire logic [7:0] TIMER_A_COUNT_I,
  input wire logic [7:0] TIMER_C_COUNT_I,
  input wire logic EXTERNAL_REQUEST_FOUR_I,
  input wire logic EXTERNAL_REQUEST_THREE_I,
  input wire logic EXTERNAL_REQUEST_ONE_I,
  input wire logic EXTERNAL_REQUEST_ZERO_I,
  input wire logic ASYNC_EVENT_COUNTER_REQUEST_I,
  input wire logic DIRECT_TRANSITION_I,
  input wire logic ADC_DONE_I,
  input wire logic TIMER_G_I,
  input wire logic TIMER_FH_I,
  input wire logic TIMER_FL_I,
  input wire logic ASYNC_EVENT_COUNTER_TWO_I,
  // Requests to the processor core
  output logic [7:0] CORE_REQUEST_ONE_O,
  output logic [7:0] CORE_REQUEST_TWO_O,
  output logic IRQ_O
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Move enable bits onto the positions of the flags they guard
  function automatic logic [7:0] align_one(input logic [7:0] en);
    align_one = {en[TIMER_A_EN_BIT], 2'b00, en[4:0]};
  endfunction : align_one

  function automatic logic [7:0] align_two(input logic [7:0] en);
    align_two = {en[TIMER_C_EN_BIT], en[6:2], 1'b0, en[0]};
  endfunction : align_two

  // ----------------------------------------------------------------------
  // Counter wrap detection
  // ----------------------------------------------------------------------
  logic [7:0] cnt_a_q;
  logic [7:0] cnt_a_d;
  logic [7:0] cnt_c_q;
  logic [7:0] cnt_c_d;
  logic seen_q;
  logic seen_d;
  logic wrap_a;
  logic wrap_c;

  // The seen bit blocks a false wrap on the first sample after reset
  always_comb
  begin
    cnt_a_d = TIMER_A_COUNT_I;
    cnt_c_d = TIMER_C_COUNT_I;
    seen_d = 1'b1;
    wrap_a = seen_q && cnt_a_q == COUNT_TOP && TIMER_A_COUNT_I == COUNT_BOTTOM; // see RQ3
    wrap_c = seen_q && ((cnt_c_q == COUNT_TOP && TIMER_C_COUNT_I == COUNT_BOTTOM) ||
                        (cnt_c_q == COUNT_BOTTOM && TIMER_C_COUNT_I == COUNT_TOP)); // see RQ6
  end

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      cnt_a_q <= REG_RESET;
      cnt_c_q <= REG_RESET;
      seen_q <= 1'b0;
    end
    else
    begin
      cnt_a_q <= cnt_a_d;
      cnt_c_q <= cnt_c_d;
      seen_q <= seen_d;
    end
  end

  // ----------------------------------------------------------------------
  // Set vectors on flag positions
  // ----------------------------------------------------------------------
  logic [7:0] set_one;
  logic [7:0] set_two;

  // Gather each source onto its own flag bit
  always_comb
  begin
    set_one = 8'h00;
    set_one[TIMER_A_FLAG_BIT] = wrap_a; // see RQ3
    set_one[EXT_FOUR_BIT] = EXTERNAL_REQUEST_FOUR_I; // see RQ2
    set_one[EXT_THREE_BIT] = EXTERNAL_REQUEST_THREE_I;
    set_one[AEC_ONE_BIT] = ASYNC_EVENT_COUNTER_REQUEST_I;
    set_one[EXT_ONE_BIT] = EXTERNAL_REQUEST_ONE_I;
    set_one[EXT_ZERO_BIT] = EXTERNAL_REQUEST_ZERO_I;
    set_two = 8'h00;
    set_two[TIMER_C_FLAG_BIT] = wrap_c; // see RQ6
    set_two[ADC_BIT] = ADC_DONE_I; // see RQ5
    set_two[TIMER_G_BIT] = TIMER_G_I;
    set_two[TIMER_FH_BIT] = TIMER_FH_I;
    set_two[TIMER_FL_BIT] = TIMER_FL_I;
    set_two[AEC_TWO_BIT] = ASYNC_EVENT_COUNTER_TWO_I;
    set_two[DIRECT_TRANS_BIT] = DIRECT_TRANSITION_I;
  end

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  logic setup;
  logic wr_en;
  logic hit_en1;
  logic hit_en2;
  logic hit_req1;
  logic hit_req2;
  logic hit_stat;
  logic hit_mask;
  logic mapped;

  // Zero wait states: read data is captured in the setup cycle
  always_comb
  begin
    hit_en1 = 1'b0;
    hit_en2 = 1'b0;
    hit_req1 = 1'b0;
    hit_req2 = 1'b0;
    hit_stat = 1'b0;
    hit_mask = 1'b0;
    if (PADDR_I == addr_of(IRQ_ENABLE_ONE_IDX))
      hit_en1 = 1'b1;
    else if (PADDR_I == addr_of(IRQ_ENABLE_TWO_IDX))
      hit_en2 = 1'b1;
    else if (PADDR_I == addr_of(IRQ_REQUEST_ONE_IDX))
      hit_req1 = 1'b1;
    else if (PADDR_I == addr_of(IRQ_REQUEST_TWO_IDX))
      hit_req2 = 1'b1;
    else if (PADDR_I == addr_of(IRQ_STATUS_IDX))
      hit_stat = 1'b1;
    else if (PADDR_I == addr_of(IRQ_MASK_IDX))
      hit_mask = 1'b1;
    mapped = hit_en1 | hit_en2 | hit_req1 | hit_req2 | hit_stat | hit_mask;
    setup = PSEL_I & ~PENABLE_I;
    wr_en = PSEL_I & PENABLE_I & PWRITE_I & mapped;
  end

  assign PREADY_O = 1'b1;
  // Unmapped accesses are refused with an error and change nothing
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;

  // ----------------------------------------------------------------------
  // Flag banks
  // ----------------------------------------------------------------------
  logic [7:0] req_one;
  logic [7:0] req_two;

  irq_flag_bank #(.IMPL(REQ_ONE_IMPL)) u_req_one
  (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .set_i(set_one),
    .wr_i(wr_en & hit_req1),
    .wdata_i(PWDATA_I[7:0]),
    .flags_o(req_one)
  ); // see RQ2

  irq_flag_bank #(.IMPL(REQ_TWO_IMPL)) u_req_two
  (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .set_i(set_two),
    .wr_i(wr_en & hit_req2),
    .wdata_i(PWDATA_I[7:0]),
    .flags_o(req_two)
  ); // see RQ5

  // ----------------------------------------------------------------------
  // Enable, status and mask registers
  // ----------------------------------------------------------------------
  logic [7:0] en_one_q;
  logic [7:0] en_one_d;
  logic [7:0] en_two_q;
  logic [7:0] en_two_d;
  logic [15:0] stat_q;
  logic [15:0] stat_d;
  logic [15:0] mask_q;
  logic [15:0] mask_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Status bits are sticky and cleared by writing one; a new event wins
  always_comb
  begin
    en_one_d = en_one_q;
    en_two_d = en_two_q;
    stat_d = stat_q;
    mask_d = mask_q;
    rdata_d = rdata_q;
    if (wr_en && hit_en1)
      en_one_d = PWDATA_I[7:0] & EN_ONE_IMPL; // see RQ1
    if (wr_en && hit_en2)
      en_two_d = PWDATA_I[7:0] & EN_TWO_IMPL; // see RQ4
    if (wr_en && hit_stat)
      stat_d = stat_q & ~PWDATA_I[15:0];
    if (wr_en && hit_mask)
      mask_d = PWDATA_I[15:0];
    stat_d = stat_d | {set_two, set_one};
    if (setup)
    begin
      rdata_d = 32'h0000_0000;
      if (hit_en1)
        rdata_d[7:0] = en_one_q;
      else if (hit_en2)
        rdata_d[7:0] = en_two_q;
      else if (hit_req1)
        rdata_d[7:0] = req_one;
      else if (hit_req2)
        rdata_d[7:0] = req_two;
      else if (hit_stat)
        rdata_d[15:0] = stat_q;
      else if (hit_mask)
        rdata_d[15:0] = mask_q;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      en_one_q <= REG_RESET;
      en_two_q <= REG_RESET;
      stat_q <= STAT_RESET;
      mask_q <= STAT_RESET;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      en_one_q <= en_one_d;
      en_two_q <= en_two_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
    end
  end

  assign PRDATA_O = rdata_q;

  // ----------------------------------------------------------------------
  // Requests to the core
  // ----------------------------------------------------------------------
  // Gated combinationally so a clear or disable drops the request at once
  assign CORE_REQUEST_ONE_O = req_one & align_one(en_one_q); // see RQ7
  assign CORE_REQUEST_TWO_O = req_two & align_two(en_two_q); // see RQ7
  assign IRQ_O = |(stat_q & mask_q);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  timer_a_set_a: assert property (@(posedge CLK_I) disable iff (RST_I) // see RQ3
    wrap_a |=> req_one[TIMER_A_FLAG_BIT])
    else $error("Timer A wrap did not set its flag");

  timer_c_set_a: assert property (@(posedge CLK_I) disable iff (RST_I) // see RQ6
    wrap_c |=> req_two[TIMER_C_FLAG_BIT])
    else $error("Timer C wrap did not set its flag");

  zero_clears_a: assert property (@(posedge CLK_I) disable iff (RST_I) // see RQ3
    (wr_en && hit_req1 && !PWDATA_I[TIMER_A_FLAG_BIT] && !wrap_a)
    |=> !req_one[TIMER_A_FLAG_BIT])
    else $error("Writing zero left the timer A flag set");

  one_keeps_a: assert property (@(posedge CLK_I) disable iff (RST_I) // see RQ7
    (wr_en && hit_req2 && PWDATA_I[TIMER_C_FLAG_BIT] && req_two[TIMER_C_FLAG_BIT])
    |=> req_two[TIMER_C_FLAG_BIT])
    else $error("Writing one cleared the timer C flag");

  enable_a_gate_a: assert property (@(posedge CLK_I) disable iff (RST_I) // see RQ1
    CORE_REQUEST_ONE_O[TIMER_A_FLAG_BIT]
    == (req_one[TIMER_A_FLAG_BIT] && en_one_q[TIMER_A_EN_BIT]))
    else $error("Timer A request does not follow flag and enable");

  enable_c_gate_a: assert property (@(posedge CLK_I) disable iff (RST_I) // see RQ4
    (wr_en && hit_en2 && !PWDATA_I[TIMER_C_EN_BIT]) |=> !CORE_REQUEST_TWO_O[TIMER_C_FLAG_BIT])
    else $error("Timer C request present while disabled");

  ext_sources_a: assert property (@(posedge CLK_I) disable iff (RST_I) // see RQ2
    EXTERNAL_REQUEST_ZERO_I |=> req_one[EXT_ZERO_BIT] && stat_q[EXT_ZERO_BIT])
    else $error("External request zero was not latched");

  adc_source_a: assert property (@(posedge CLK_I) disable iff (RST_I) // see RQ5
    (ADC_DONE_I && wr_en && hit_req2) |=> req_two[ADC_BIT])
    else $error("Converter event lost against a clear");

  request_gate_a: assert property (@(posedge CLK_I) disable iff (RST_I) // see RQ7
    (CORE_REQUEST_TWO_O & ~req_two) == 8'h00)
    else $error("Request presented without its flag");

  enable_off_a: assert property (@(posedge CLK_I) disable iff (RST_I) // see RQ7
    (wr_en && hit_en1 && PWDATA_I[7:0] == 8'h00) |=> CORE_REQUEST_ONE_O == 8'h00)
    else $error("Request one still presented after all enables cleared");

endmodule : timer_interrupt_flags

// >>> irq_flags_pkg.sv
// Package with register map, field positions and reset values of the timer interrupt flags
package irq_flags_pkg;

  // ----------------------------------------------------------------------
  // Register indices (printed offsets) and their APB byte addresses
  // ----------------------------------------------------------------------
  localparam logic [15:0] IRQ_ENABLE_ONE_IDX = 16'hfff3;
  localparam logic [15:0] IRQ_ENABLE_TWO_IDX = 16'hfff4;
  localparam logic [15:0] IRQ_REQUEST_ONE_IDX = 16'hfff6;
  localparam logic [15:0] IRQ_REQUEST_TWO_IDX = 16'hfff7;
  localparam logic [15:0] IRQ_STATUS_IDX = 16'hfff8;
  localparam logic [15:0] IRQ_MASK_IDX = 16'hfff9;

  // Byte address of a word register is four times its index
  function automatic logic [31:0] addr_of(input logic [15:0] idx);
    addr_of = {14'h0000, idx, 2'b00};
  endfunction : addr_of

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int TIMER_A_EN_BIT = 5;
  localparam int TIMER_A_FLAG_BIT = 7;
  localparam int EXT_FOUR_BIT = 4;
  localparam int EXT_THREE_BIT = 3;
  localparam int AEC_ONE_BIT = 2;
  localparam int EXT_ONE_BIT = 1;
  localparam int EXT_ZERO_BIT = 0;
  localparam int TIMER_C_EN_BIT = 1;
  localparam int TIMER_C_FLAG_BIT = 7;
  localparam int ADC_BIT = 6;
  localparam int TIMER_G_BIT = 5;
  localparam int TIMER_FH_BIT = 4;
  localparam int TIMER_FL_BIT = 3;
  localparam int AEC_TWO_BIT = 2;
  localparam int DIRECT_TRANS_BIT = 0;

  // Implemented bits; all others read as zero
  localparam logic [7:0] REQ_ONE_IMPL = 8'h9f;
  localparam logic [7:0] REQ_TWO_IMPL = 8'hfd;
  localparam logic [7:0] EN_ONE_IMPL = 8'h3f;
  localparam logic [7:0] EN_TWO_IMPL = 8'h7f;

  // ----------------------------------------------------------------------
  // Reset values and counter wrap points
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] STAT_RESET = 16'h0000;
  localparam logic [7:0] COUNT_TOP = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

endpackage : irq_flags_pkg

// >>> irq_flag_bank.sv
// Eight request flags: hardware sets, software clears by writing zero
module irq_flag_bank
  import irq_flags_pkg::*;
#(
  parameter logic [7:0] IMPL = 8'hff
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] set_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] flags_o
);

  logic [7:0] flags_q;
  logic [7:0] flags_d;

  // ----------------------------------------------------------------------
  // Next value
  // ----------------------------------------------------------------------
  // Set wins over a clear in the same cycle so no event is lost
  always_comb
  begin
    flags_d = flags_q;
    if (wr_i)
    begin
      flags_d = flags_q & wdata_i; // Writing one leaves a flag alone
    end
    flags_d = (flags_d | set_i) & IMPL;
  end

  // Register only
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      flags_q <= REG_RESET;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  assign flags_o = flags_q;

endmodule : irq_flag_bank

// >>> irq_core_model.sv
// Processor core model: records every interrupt request the block offers it
module irq_core_model
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] req_one_i,
  input wire logic [7:0] req_two_i,
  input wire logic irq_i,
  output logic [7:0] seen_one_o,
  output logic [7:0] seen_two_o,
  output logic irq_seen_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [16:0] seen_d;
  logic [16:0] seen_q;

  // Sticky record; the core never gates requests, so a leak shows up here
  always_comb
  begin
    seen_d = seen_q | {irq_i, req_two_i, req_one_i};
  end

  // Record storage
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      seen_q <= 17'h00000;
    end
    else
    begin
      seen_q <= seen_d;
    end
  end

  assign {irq_seen_o, seen_two_o, seen_one_o} = seen_q;
endmodule : irq_core_model

// >>> testbench.sv
// Self-checking bench for the timer interrupt flag block
module testbench
  import irq_flags_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, psel, pen, pwr, perr, pready, irq, err, irq_seen;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [7:0] cnt_a, cnt_c, core1, core2, seen1, seen2;
  logic [10:0] src_q;
  int fail_count, cmp_count, cyc;
  // Expected flags per source: ext4, ext3, ext1, ext0, counter, transition, ADC, G, FH, FL, counter
  logic [7:0] e1 [11] = '{8'h10, 8'h08, 8'h02, 8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] e2 [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04};

  timer_interrupt_flags timer_interrupt_flags_inst (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(perr), .TIMER_A_COUNT_I(cnt_a), .TIMER_C_COUNT_I(cnt_c),
    .EXTERNAL_REQUEST_FOUR_I(src_q[0]), .EXTERNAL_REQUEST_THREE_I(src_q[1]),
    .EXTERNAL_REQUEST_ONE_I(src_q[2]), .EXTERNAL_REQUEST_ZERO_I(src_q[3]),
    .ASYNC_EVENT_COUNTER_REQUEST_I(src_q[4]), .DIRECT_TRANSITION_I(src_q[5]),
    .ADC_DONE_I(src_q[6]), .TIMER_G_I(src_q[7]), .TIMER_FH_I(src_q[8]), .TIMER_FL_I(src_q[9]),
    .ASYNC_EVENT_COUNTER_TWO_I(src_q[10]), .CORE_REQUEST_ONE_O(core1),
    .CORE_REQUEST_TWO_O(core2), .IRQ_O(irq));

  irq_core_model irq_core_model_inst (.clk_i(clk), .rst_i(rst), .req_one_i(core1),
    .req_two_i(core2), .irq_i(irq), .seen_one_o(seen1), .seen_two_o(seen2),
    .irq_seen_o(irq_seen));

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // One APB transfer; waits for pready with no assumed latency
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {14'h0000, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(negedge clk);
  endtask : apb

  task automatic rdchk(input logic [15:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0);
    chk(rd, e);
  endtask : rdchk

  // Count pair seen on two consecutive edges; the count then stays at b
  task automatic wrap(input logic sel, input logic [7:0] a, input logic [7:0] b);
    @(posedge clk);
    if (sel)
      cnt_c <= a;
    else
      cnt_a <= a;
    @(posedge clk);
    if (sel)
      cnt_c <= b;
    else
      cnt_a <= b;
    @(posedge clk);
    @(negedge clk);
  endtask : wrap

  task automatic pulse(input int i);
    @(posedge clk);
    src_q <= 11'h001 << i;
    @(posedge clk);
    src_q <= 11'h000;
    @(negedge clk);
  endtask : pulse

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic test_timer_a();
    rdchk(IRQ_REQUEST_ONE_IDX, 32'h0);
    wrap(1'b0, 8'h00, 8'hff);
    rdchk(IRQ_REQUEST_ONE_IDX, 32'h0);
    wrap(1'b0, 8'hff, 8'h00);
    rdchk(IRQ_REQUEST_ONE_IDX, 32'h80);
    chk(32'(seen1), 32'h0);
    apb(1'b1, IRQ_ENABLE_ONE_IDX, 32'h20);
    chk(32'(core1), 32'h80);
    apb(1'b1, IRQ_ENABLE_ONE_IDX, 32'h00);
    chk(32'(core1), 32'h0);
    apb(1'b1, IRQ_ENABLE_ONE_IDX, 32'h20);
    chk(32'(core1), 32'h80);
    apb(1'b1, IRQ_REQUEST_ONE_IDX, 32'h80);
    rdchk(IRQ_REQUEST_ONE_IDX, 32'h80);
    apb(1'b1, IRQ_REQUEST_ONE_IDX, 32'h00);
    rdchk(IRQ_REQUEST_ONE_IDX, 32'h0);
    chk(32'(core1), 32'h0);
    chk(32'(seen1), 32'h80);
  endtask : test_timer_a

  task automatic test_timer_c();
    chk(32'(seen2), 32'h0);
    apb(1'b1, IRQ_ENABLE_TWO_IDX, 32'h02);
    wrap(1'b1, 8'hff, 8'h00);
    rdchk(IRQ_REQUEST_TWO_IDX, 32'h80);
    chk(32'(core2), 32'h80);
    apb(1'b1, IRQ_REQUEST_TWO_IDX, 32'h80);
    rdchk(IRQ_REQUEST_TWO_IDX, 32'h80);
    apb(1'b1, IRQ_ENABLE_TWO_IDX, 32'h00);
    chk(32'(core2), 32'h0);
    apb(1'b1, IRQ_ENABLE_TWO_IDX, 32'h02);
    chk(32'(core2), 32'h80);
    apb(1'b1, IRQ_REQUEST_TWO_IDX, 32'h00);
    wrap(1'b1, 8'h00, 8'hff);
    rdchk(IRQ_REQUEST_TWO_IDX, 32'h80);
    apb(1'b1, IRQ_REQUEST_TWO_IDX, 32'h00);
    wrap(1'b1, 8'h7f, 8'h80);
    rdchk(IRQ_REQUEST_TWO_IDX, 32'h0);
    chk(32'(core2), 32'h0);
    chk(32'(seen2), 32'h80);
  endtask : test_timer_c

  task automatic test_sources();
    apb(1'b1, IRQ_ENABLE_ONE_IDX, 32'h3f);
    apb(1'b1, IRQ_ENABLE_TWO_IDX, 32'h7f);
    for (int i = 0; i < 11; i++)
    begin
      pulse(i);
      rdchk(IRQ_REQUEST_ONE_IDX, 32'(e1[i]));
      rdchk(IRQ_REQUEST_TWO_IDX, 32'(e2[i]));
      chk(32'({core2, core1}), 32'({e2[i], e1[i]}));
      apb(1'b1, IRQ_REQUEST_ONE_IDX, 32'h0);
      apb(1'b1, IRQ_REQUEST_TWO_IDX, 32'h0);
    end
    // A clear of request two lands on the edge that sees the converter event
    fork
      apb(1'b1, IRQ_REQUEST_TWO_IDX, 32'h00);
      begin
        @(posedge clk);
        pulse(6);
      end
    join
    rdchk(IRQ_REQUEST_TWO_IDX, 32'h40);
    apb(1'b1, IRQ_REQUEST_TWO_IDX, 32'h0);
  endtask : test_sources

  // Sticky status, mask, level output, then an unmapped access
  task automatic test_irq();
    apb(1'b1, IRQ_STATUS_IDX, 32'hffff);
    rdchk(IRQ_STATUS_IDX, 32'h0);
    pulse(3);
    rdchk(IRQ_STATUS_IDX, 32'h1);
    chk(32'(irq), 32'h0);
    apb(1'b1, IRQ_MASK_IDX, 32'h1);
    chk(32'(irq), 32'h1);
    rdchk(IRQ_MASK_IDX, 32'h1);
    chk(32'(err), 32'h0);
    apb(1'b1, IRQ_STATUS_IDX, 32'h1);
    chk(32'(irq), 32'h0);
    chk(32'(irq_seen), 32'h1);
    apb(1'b1, 16'hfff5, 32'hff);
    chk(32'(err), 32'h1);
    rdchk(16'hfff5, 32'h0);
    chk(32'(err), 32'h1);
  endtask : test_irq

  // Mid-run reset clears flags, enables, status and mask
  task automatic test_reset();
    pulse(3);
    chk(32'(irq), 32'h1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(32'({irq, core2, core1}), 32'h0);
    rdchk(IRQ_REQUEST_ONE_IDX, 32'h0);
    rdchk(IRQ_ENABLE_ONE_IDX, 32'h0);
    rdchk(IRQ_ENABLE_TWO_IDX, 32'h0);
    rdchk(IRQ_MASK_IDX, 32'h0);
    rdchk(IRQ_STATUS_IDX, 32'h0);
  endtask : test_reset

  task automatic tally_and_finish();
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // Hang guard: far above the few hundred cycles the run needs
  initial
  begin
    cyc = 0;
    forever
    begin
      @(posedge clk);
      cyc++;
      if (cyc == 20000)
      begin
        fail_count++;
        tally_and_finish();
      end
    end
  end

  // Main sequence
  initial
  begin
    {psel, pen, pwr, paddr, pwdata, src_q} = '0;
    cnt_a = 8'h10;
    cnt_c = 8'h10;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(32'(irq), 32'h0);
    rdchk(IRQ_ENABLE_ONE_IDX, 32'h0);
    rdchk(IRQ_ENABLE_TWO_IDX, 32'h0);
    test_timer_a();
    test_timer_c();
    test_sources();
    test_irq();
    test_reset();
    tally_and_finish();
  end
endmodule : testbench
